// File: inc/code_privilege_protection_map.svh
// register offsets, field positions, reset values and timing counts of the protection block
`ifndef CODE_PRIVILEGE_PROTECTION_MAP_SVH
`define CODE_PRIVILEGE_PROTECTION_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CPP_OFF_CTRL        12'h000
`define CPP_OFF_PRIV        12'h004
`define CPP_OFF_STAGE_ONE   12'h008
`define CPP_OFF_STAGE_TWO   12'h00c
`define CPP_OFF_LOADER_PAGE 12'h010
`define CPP_OFF_APP_PAGE    12'h014
`define CPP_OFF_STATUS      12'h018

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CPP_CTRL_PE_BIT     0
`define CPP_CTRL_FIRQ_BIT   1
`define CPP_STAT_PEXC_BIT   0
`define CPP_STAT_MFLT_BIT   1
`define CPP_PRIV_SYS_WR     3
`define CPP_PRIV_SYS_RD     2
`define CPP_PRIV_LDR_WR     1
`define CPP_PRIV_LDR_RD     0
`define CPP_PAGE_SHIFT      8
`define CPP_FLASH_MAP_BIT   15

// ----------------------------------------------------------------------------
// privilege constants and reset values
// ----------------------------------------------------------------------------
`define CPP_PRIV_HIGH       4'hf
`define CPP_PRIV_MEDIUM     4'h3
`define CPP_PRIV_LOW        4'h0
`define CPP_RST_PAGE        8'h80
`define CPP_RST_PE          1'b1
`define CPP_RST_FIRQ        1'b1
`define CPP_RST_IP          16'h8000
`define CPP_APB_WAIT        1

`endif

// File: inc/code_privilege_protection_pkg.sv
// types shared by the protection block and its helpers
package code_privilege_protection_pkg;

  // --------------------------------------------------------------------------
  // regions and execution sources
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    REG_SYS = 3'b001,
    REG_LDR = 3'b010,
    REG_APP = 3'b100
  } region_t;

  typedef enum logic [2:0] {
    SRC_FLASH = 3'b001,
    SRC_UROM  = 3'b010,
    SRC_RAM   = 3'b100
  } exec_src_t;

  typedef logic [3:0] priv_t;

  // --------------------------------------------------------------------------
  // core-side carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        code;
    logic [15:0] addr;
  } access_req_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  idx;
    logic [15:0] addr;
  } ptr_act_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] target;
  } jump_t;

endpackage : code_privilege_protection_pkg

// File: design/region_decode.sv
// page compare of one address against the two region boundaries
`timescale 1ns/1ps
`include "code_privilege_protection_map.svh"
module region_decode (
  input  wire logic [15:0]                              addr,       // word address
  input  wire logic [7:0]                               loaderPage, // loader base page
  input  wire logic [7:0]                               appPage,    // application base page
  output code_privilege_protection_pkg::region_t        region      // region of addr
);

  logic [7:0] page;

  assign page = addr[15:`CPP_PAGE_SHIFT];

  // --------------------------------------------------------------------------
  // region select
  // --------------------------------------------------------------------------
  always_comb begin
    if (page < loaderPage) begin
      region = code_privilege_protection_pkg::REG_SYS;
    end else if (page < appPage) begin
      region = code_privilege_protection_pkg::REG_LDR;
    end else begin
      region = code_privilege_protection_pkg::REG_APP;
    end
  end

endmodule : region_decode

// File: design/pointer_prefetch.sv
// holding words fetched when a pointer is activated, handed out on operand use
`timescale 1ns/1ps
module pointer_prefetch #(
  parameter int NPTR  = 3,
  parameter int WIDTH = 16
) (
  input  wire logic                    clk,         // system clock
  input  wire logic                    reset_n,     // synchronous reset, low
  input  wire logic                    capture,     // fetched word arrives
  input  wire logic [1:0]              captureIdx,  // pointer that fetched
  input  wire logic [WIDTH-1:0]        captureData, // fetched word
  input  wire logic                    drop,        // activation refused
  input  wire logic [1:0]              dropIdx,     // pointer refused
  input  wire logic                    useValid,    // pointer read as source
  input  wire logic [1:0]              useIdx,      // pointer read
  output logic      [WIDTH-1:0]        srcData,     // held word to destination
  output logic                         srcValid     // held word was valid
);

  logic [WIDTH-1:0] held    [NPTR];
  logic [NPTR-1:0]  heldOk;

  // --------------------------------------------------------------------------
  // one holding slot per pointer
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < NPTR; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        held[i]   <= '0;
        heldOk[i] <= 1'b0;
      end else if (capture && captureIdx == 2'(i)) begin
        held[i]   <= captureData;
        heldOk[i] <= 1'b1;
      end else if (drop && dropIdx == 2'(i)) begin
        heldOk[i] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // operand delivery
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      srcData  <= '0;
      srcValid <= 1'b0;
    end else begin
      srcData  <= useValid ? held[useIdx] : srcData;
      srcValid <= useValid && heldOk[useIdx];
    end
  end

endmodule : pointer_prefetch

// File: design/code_privilege_protection.sv
// privilege tracking, access checking and pointer prefetch with an APB register file
//
// Notes on behaviour
// - excess over privilege raises privilege exception
// - high write from user, low system read
// - denied access blocked and reported
// - pointer activation reads memory at once
// - source use returns held prefetched word
// - RAM-code pointer writes are checked activations
// - RAM activation into system flash faults
// - flash execution maps RAM/ROM, never faults
// - protection enabled blocks system-code debug
// - ROM clears enable only for empty password; here any APB write to CTRL sets or clears enable, with no password
// - reset execution starts at 8000h
// - region pages reset to 80h
// - reset privilege high, protection enabled
// - jump to loader base drops to medium
// - jump to application base drops to low
// - privilege never above running region maximum
// - three flash areas, ROM high, RAM low
// - four privilege bits, high/medium/low codes
// - two-stage write takes minimum; direct write clears
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "code_privilege_protection_map.svh"
module code_privilege_protection #(
  parameter int NPTR = 3
) (
  input  wire logic                                       clk,        // 250 MHz clock
  input  wire logic                                       reset_n,    // sync reset, low
  input  wire logic [11:0]                                paddr,      // APB address
  input  wire logic                                       psel,       // APB select
  input  wire logic                                       penable,    // APB enable
  input  wire logic                                       pwrite,     // APB direction
  input  wire logic [31:0]                                pwdata,     // APB write data
  output logic      [31:0]                                prdata,     // APB read data
  output logic                                            pready,     // APB ready
  output logic                                            pslverr,    // APB error
  input  wire logic [15:0]                                ipAddr,     // instruction pointer
  input  wire code_privilege_protection_pkg::exec_src_t   execSrc,    // memory executing from
  input  wire code_privilege_protection_pkg::jump_t       jump,       // taken jump
  input  wire code_privilege_protection_pkg::access_req_t acc,        // memory access request
  input  wire code_privilege_protection_pkg::ptr_act_t    ptrAct,     // pointer activation
  input  wire logic                                       ptrUse,     // pointer used as source
  input  wire logic [1:0]                                 ptrUseIdx,  // pointer used
  input  wire logic [15:0]                                memRdata,   // memory read data
  output logic                                            memCe,      // memory chip enable
  output logic      [15:0]                                memAddr,    // memory read address
  output logic      [15:0]                                srcData,    // prefetched operand
  output logic                                            srcValid,   // operand was prefetched
  output logic                                            accGrant,   // access allowed
  output logic                                            accDenied,  // access blocked
  output logic                                            privIrq,    // privilege exception
  output logic                                            faultIrq,   // memory fault interrupt
  output logic                                            debugLock,  // system debug disabled
  output logic      [15:0]                                bootAddr,   // reset start address
  output code_privilege_protection_pkg::priv_t            privLevel   // current privilege
);

  code_privilege_protection_pkg::priv_t   curPriv;
  code_privilege_protection_pkg::priv_t   stageOne;
  code_privilege_protection_pkg::priv_t   ipMax;
  code_privilege_protection_pkg::region_t ipRegion;
  code_privilege_protection_pkg::region_t accRegion;
  code_privilege_protection_pkg::region_t actRegion;
  logic [7:0]  loaderPage;
  logic [7:0]  appPage;
  logic        protEnable;
  logic        faultIrqEn;
  logic        privExc;
  logic        memFault;
  logic        apbDo;
  logic        apbWr;
  logic        apbRd;
  logic        hitCtrl;
  logic        hitPriv;
  logic        hitOne;
  logic        hitTwo;
  logic        hitLdr;
  logic        hitApp;
  logic        hitStat;
  logic        hitAny;
  logic        accCheck;
  logic        accOk;
  logic        actDeny;
  logic        actGo;
  logic        privOver;
  logic        fetchPend;
  logic [1:0]  fetchIdx;
  logic [3:0]  wrPriv;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic code_privilege_protection_pkg::priv_t pmin(
    input code_privilege_protection_pkg::priv_t a,
    input code_privilege_protection_pkg::priv_t b
  );
    pmin = (a < b) ? a : b;
  endfunction : pmin

  // --------------------------------------------------------------------------
  // region decode
  // --------------------------------------------------------------------------
  // region compare
  region_decode u_ip_region (
    .addr       (ipAddr),
    .loaderPage (loaderPage),
    .appPage    (appPage),
    .region     (ipRegion)
  );

  region_decode u_acc_region (
    .addr       (acc.addr),
    .loaderPage (loaderPage),
    .appPage    (appPage),
    .region     (accRegion)
  );

  region_decode u_act_region (
    .addr       (ptrAct.addr),
    .loaderPage (loaderPage),
    .appPage    (appPage),
    .region     (actRegion)
  );

  always_comb begin
    ipMax = `CPP_PRIV_LOW;
    if (execSrc == code_privilege_protection_pkg::SRC_UROM) begin
      ipMax = `CPP_PRIV_HIGH;
    end else if (execSrc == code_privilege_protection_pkg::SRC_FLASH) begin
      case (ipRegion)
        code_privilege_protection_pkg::REG_SYS: ipMax = `CPP_PRIV_HIGH;
        code_privilege_protection_pkg::REG_LDR: ipMax = `CPP_PRIV_MEDIUM;
        default:                                ipMax = `CPP_PRIV_LOW;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign apbDo   = psel && penable && pready;
  assign apbWr   = apbDo && pwrite;
  assign apbRd   = psel && penable && !pready && !pwrite;
  assign hitCtrl = (paddr == `CPP_OFF_CTRL);
  assign hitPriv = (paddr == `CPP_OFF_PRIV);
  assign hitOne  = (paddr == `CPP_OFF_STAGE_ONE);
  assign hitTwo  = (paddr == `CPP_OFF_STAGE_TWO);
  assign hitLdr  = (paddr == `CPP_OFF_LOADER_PAGE);
  assign hitApp  = (paddr == `CPP_OFF_APP_PAGE);
  assign hitStat = (paddr == `CPP_OFF_STATUS);
  assign hitAny  = hitCtrl || hitPriv || hitOne || hitTwo || hitLdr || hitApp || hitStat;
  assign wrPriv  = pwdata[3:0];

  assign privOver = apbWr && hitPriv && ((wrPriv & ~ipMax) != 4'h0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hitAny;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (apbRd) begin
      if (hitCtrl) begin
        prdata <= {30'h0, faultIrqEn, protEnable};
      end else if (hitPriv) begin
        prdata <= {28'h0, curPriv};
      end else if (hitOne) begin
        prdata <= {28'h0, stageOne};
      end else if (hitLdr) begin
        prdata <= {24'h0, loaderPage};
      end else if (hitApp) begin
        prdata <= {24'h0, appPage};
      end else if (hitStat) begin
        prdata <= {30'h0, memFault, privExc};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      protEnable <= `CPP_RST_PE;
      faultIrqEn <= `CPP_RST_FIRQ;
    end else if (apbWr && hitCtrl) begin
      protEnable <= pwdata[`CPP_CTRL_PE_BIT];
      faultIrqEn <= pwdata[`CPP_CTRL_FIRQ_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      loaderPage <= `CPP_RST_PAGE;
      appPage    <= `CPP_RST_PAGE;
    end else begin
      // loader page loaded by any APB write to its offset, whatever the privilege
      if (apbWr && hitLdr) begin
        loaderPage <= pwdata[7:0];
      end
      if (apbWr && hitApp) begin
        appPage <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // privilege tracking
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      curPriv <= `CPP_PRIV_HIGH;
    end else if (apbWr && hitPriv) begin
      curPriv <= pmin(wrPriv, ipMax);
    end else if (apbWr && hitTwo) begin
      curPriv <= pmin(pmin(stageOne, wrPriv), ipMax);
    end else if (jump.valid && jump.target[7:0] == 8'h00 &&
                 jump.target[15:`CPP_PAGE_SHIFT] == appPage) begin
      curPriv <= `CPP_PRIV_LOW;
    end else if (jump.valid && jump.target[7:0] == 8'h00 &&
                 jump.target[15:`CPP_PAGE_SHIFT] == loaderPage) begin
      curPriv <= pmin(pmin(curPriv, `CPP_PRIV_MEDIUM), ipMax);
    end else begin
      curPriv <= pmin(curPriv, ipMax);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stageOne <= `CPP_PRIV_LOW;
    end else if (apbWr && hitPriv) begin
      stageOne <= `CPP_PRIV_LOW;
    end else if (apbWr && hitOne) begin
      stageOne <= pmin(wrPriv, ipMax);
    end else begin
      stageOne <= pmin(stageOne, ipMax);
    end
  end

  // --------------------------------------------------------------------------
  // access check
  // --------------------------------------------------------------------------
  // data space from flash or ROM is unchecked
  assign accCheck = protEnable && (acc.code ||
                    (execSrc == code_privilege_protection_pkg::SRC_RAM &&
                     !acc.addr[`CPP_FLASH_MAP_BIT]));

  // system read needs system read bit
  always_comb begin
    accOk = 1'b1;
    if (accCheck) begin
      case (accRegion)
        code_privilege_protection_pkg::REG_SYS:
          accOk = acc.write ? curPriv[`CPP_PRIV_SYS_WR] : curPriv[`CPP_PRIV_SYS_RD];
        code_privilege_protection_pkg::REG_LDR:
          accOk = acc.write ? curPriv[`CPP_PRIV_LDR_WR] : curPriv[`CPP_PRIV_LDR_RD];
        default:
          accOk = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accGrant  <= 1'b0;
      accDenied <= 1'b0;
    end else begin
      accGrant  <= acc.valid && accOk;
      accDenied <= acc.valid && !accOk;
    end
  end

  // --------------------------------------------------------------------------
  // pointer activation
  // --------------------------------------------------------------------------
  // RAM-code activation checked
  assign actDeny = ptrAct.valid && protEnable &&
                   execSrc == code_privilege_protection_pkg::SRC_RAM &&
                   !ptrAct.addr[`CPP_FLASH_MAP_BIT] &&
                   actRegion == code_privilege_protection_pkg::REG_SYS;
  assign actGo   = ptrAct.valid && !actDeny;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memCe     <= 1'b0;
      memAddr   <= 16'h0000;
      fetchPend <= 1'b0;
      fetchIdx  <= 2'h0;
    end else begin
      memCe     <= actGo;
      memAddr   <= actGo ? ptrAct.addr : memAddr;
      fetchPend <= actGo;
      fetchIdx  <= actGo ? ptrAct.idx : fetchIdx;
    end
  end

  pointer_prefetch #(
    .NPTR  (NPTR),
    .WIDTH (16)
  ) u_prefetch (
    .clk         (clk),
    .reset_n     (reset_n),
    .capture     (fetchPend),
    .captureIdx  (fetchIdx),
    .captureData (memRdata),
    .drop        (actDeny),
    .dropIdx     (ptrAct.idx),
    .useValid    (ptrUse),
    .useIdx      (ptrUseIdx),
    .srcData     (srcData),
    .srcValid    (srcValid)
  );

  // --------------------------------------------------------------------------
  // sticky flags and outputs
  // --------------------------------------------------------------------------
  // set wins over write-one clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      privExc  <= 1'b0;
      memFault <= 1'b0;
    end else begin
      privExc  <= (acc.valid && !accOk) || privOver ||
                  (privExc && !(apbWr && hitStat && pwdata[`CPP_STAT_PEXC_BIT]));
      memFault <= actDeny ||
                  (memFault && !(apbWr && hitStat && pwdata[`CPP_STAT_MFLT_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      privIrq   <= 1'b0;
      faultIrq  <= 1'b0;
      debugLock <= 1'b1;
      bootAddr  <= `CPP_RST_IP;
      privLevel <= `CPP_PRIV_HIGH;
    end else begin
      privIrq   <= privExc;
      faultIrq  <= memFault && faultIrqEn;
      debugLock <= protEnable;
      bootAddr  <= bootAddr;
      privLevel <= curPriv;
    end
  end

endmodule : code_privilege_protection

// File: dv/code_privilege_protection_checker.sv
// port assertions of the protection block
`timescale 1ns/1ps
module code_privilege_protection_checker (
  input wire logic                                       clk,       // clock
  input wire logic                                       reset_n,   // reset, low
  input wire logic                                       pready,    // apb ready
  input wire code_privilege_protection_pkg::exec_src_t   execSrc,   // exec source
  input wire code_privilege_protection_pkg::access_req_t acc,       // access
  input wire code_privilege_protection_pkg::ptr_act_t    ptrAct,    // activation
  input wire logic                                       memCe,     // chip enable
  input wire logic [15:0]                                memAddr,   // read address
  input wire logic                                       accGrant,  // granted
  input wire logic                                       accDenied, // denied
  input wire logic                                       privIrq,   // exception
  input wire logic                                       faultIrq,  // fault
  input wire logic                                       debugLock, // debug off
  input wire logic [15:0]                                bootAddr,  // start address
  input wire code_privilege_protection_pkg::priv_t       privLevel  // privilege
);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence actRead;
    memCe && memAddr == $past(ptrAct.addr);
  endsequence
  sequence inRam;
    execSrc == code_privilege_protection_pkg::SRC_RAM;
  endsequence
  AST_BOOT: assert property (bootAddr == 16'h8000) else $error("bad boot address");
  AST_ACK: assert property (acc.valid |=> accGrant != accDenied)
    else $error("access not answered");
  AST_DENY_IRQ: assert property (accDenied |=> privIrq) else $error("no exception");
  AST_ACT_CE: assert property (ptrAct.valid && execSrc ==
    code_privilege_protection_pkg::SRC_FLASH |=> actRead) else $error("no activation read");
  AST_PRIV_CAP: assert property (inRam [*3] |-> privLevel == 4'h0)
    else $error("privilege above region");
  AST_DEBUG_LOCK: assert property ($changed(debugLock) |-> $past(pready, 2))
    else $error("debug lock moved alone");
  AST_FAULT: assert property ($rose(faultIrq) |->
    $past(execSrc, 2) == code_privilege_protection_pkg::SRC_RAM) else $error("stray fault");
  AST_SYS_READ: assert property (acc.valid && acc.code && acc.addr[15:8] == 8'h00 ##1
    privLevel == 4'h0 && debugLock |-> accDenied) else $error("system read allowed");
endmodule : code_privilege_protection_checker

bind code_privilege_protection code_privilege_protection_checker chk_i (.clk, .reset_n,
  .pready, .execSrc, .acc, .ptrAct, .memCe, .memAddr, .accGrant, .accDenied, .privIrq,
  .faultIrq, .debugLock, .bootAddr, .privLevel);

// File: dv/mem_model.sv
// memory answering activation reads
`timescale 1ns/1ps
module mem_model (
  input  wire logic        memCe,              // chip enable
  input  wire logic [15:0] memAddr,            // read address
  output logic      [15:0] memRdata            // read word
);
  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  // data from memory
  // word stands while chip enable is high; wrong word otherwise
  always_comb begin
    memRdata = memCe ? (memAddr ^ 16'h5a5a) : ~(memAddr ^ 16'h5a5a);
  end
endmodule : mem_model

// File: dv/tb.sv
// self-checking bench of the protection block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ptrUse = 1'b0, pready, pslverr, memCe, srcValid, accGrant, accDenied, sl;
  logic        privIrq, faultIrq, debugLock;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] ipAddr = 16'h8000, memRdata, memAddr, srcData, bootAddr;
  logic [3:0]  privLevel;
  int          fail_count, total_checks;
  logic [11:0] frame_offset [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
  logic [31:0] rstv [7] = '{32'h3, 32'hf, 32'h0, 32'h0, 32'h80, 32'h80, 32'h0};
  code_privilege_protection_pkg::exec_src_t   execSrc = code_privilege_protection_pkg::SRC_UROM;
  code_privilege_protection_pkg::jump_t       jump    = '0;
  code_privilege_protection_pkg::access_req_t acc     = '0;
  code_privilege_protection_pkg::ptr_act_t    ptrAct  = '0;

  code_privilege_protection #(.NPTR(3)) code_privilege_protection_i (.clk, .reset_n, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ipAddr, .execSrc, .jump,
    .acc, .ptrAct, .ptrUse, .ptrUseIdx(2'b00), .memRdata, .memCe, .memAddr, .srcData,
    .srcValid, .accGrant, .accDenied, .privIrq, .faultIrq, .debugLock, .bootAddr, .privLevel);
  mem_model mem_model_i (.memCe, .memAddr, .memRdata);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    sl = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", ex, rd)
  endtask : rdchk

  // one-cycle pulse: 0 access, 1 activation, 2 jump, 3 source use
  task automatic act(input int k, input logic [15:0] a);
    @(posedge clk);
    case (k)
      0: acc <= '{1'b1, 1'b0, 1'b1, a};
      1: ptrAct <= '{1'b1, 2'b00, a};
      2: jump <= '{1'b1, a};
      default: ptrUse <= 1'b1;
    endcase
    @(posedge clk);
    acc.valid    <= 1'b0;
    ptrAct.valid <= 1'b0;
    jump.valid   <= 1'b0;
    ptrUse       <= 1'b0;
    @(negedge clk);
  endtask : act

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    `CHK("bootAddr", 16'h8000, bootAddr)
    `CHK("privLevel", 4'hf, privLevel)
    for (int i = 0; i < 7; i++) begin
      rdchk(frame_offset[i], rstv[i]);
    end
    apb(1'b1, 12'h01c, 32'h1);
    `CHK("pslverr", 1'b1, sl)
    apb(1'b1, 12'h000, 32'h2);
    repeat (2) @(negedge clk);
    `CHK("debugLock", 1'b0, debugLock)
    apb(1'b1, 12'h000, 32'h3);
    execSrc <= code_privilege_protection_pkg::SRC_FLASH;
    ipAddr  <= 16'h0000;
    apb(1'b1, 12'h010, 32'h20);
    apb(1'b1, 12'h014, 32'h40);
    rdchk(12'h010, 32'h20);
    rdchk(12'h014, 32'h40);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h00c, 32'hf);
    rdchk(12'h004, 32'h3);
    apb(1'b1, 12'h004, 32'hf);
    rdchk(12'h008, 32'h0);
    rdchk(12'h004, 32'hf);
    act(2, 16'h2000);
    @(negedge clk);
    `CHK("privLevel", 4'h3, privLevel)
    @(posedge clk);
    ipAddr <= 16'h2000;
    act(2, 16'h4000);
    @(negedge clk);
    `CHK("privLevel", 4'h0, privLevel)
    @(posedge clk);
    ipAddr <= 16'h4000;
    apb(1'b1, 12'h004, 32'hf);
    rdchk(12'h004, 32'h0);
    `CHK("privIrq", 1'b1, privIrq)
    execSrc <= code_privilege_protection_pkg::SRC_RAM;
    act(0, 16'h0010);
    `CHK("accDenied", 1'b1, accDenied)
    act(0, 16'h4010);
    `CHK("accGrant", 1'b1, accGrant)
    act(1, 16'h0000);
    `CHK("memCe", 1'b0, memCe)
    repeat (2) @(negedge clk);
    `CHK("faultIrq", 1'b1, faultIrq)
    rdchk(12'h018, 32'h3);
    apb(1'b1, 12'h018, 32'h3);
    execSrc <= code_privilege_protection_pkg::SRC_FLASH;
    act(1, 16'h0123);
    `CHK("memAddr", 16'h0123, memAddr)
    repeat (3) @(posedge clk);
    act(3, 16'h0000);
    `CHK("srcData", 16'h0123 ^ 16'h5a5a, srcData)
    `CHK("srcValid", 1'b1, srcValid)
    `CHK("privIrq", 1'b0, privIrq)
    `CHK("faultIrq", 1'b0, faultIrq)
    report_and_stop();
  end
endmodule : tb
